// ### sfd_pkg.sv
// Constants and carrier types for the speaker fault diagnostic sequencer.
// Assumes a 100 MHz system clock; all times below derive their cycle counts from it.
package sfd_pkg;
	localparam int CLK_NS = 10;
	localparam int RECHECK_US = 1000;
	localparam int ACQ_MS = 100;
	localparam int FMUTE_US = 1500;
	localparam int NMUTE_MS = 20;
	localparam int RECHECK_CYC = (RECHECK_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int ACQ_CYC = (ACQ_MS * 1000000 + CLK_NS - 1) / CLK_NS;
	localparam int FMUTE_CYC = (FMUTE_US * 1000) / CLK_NS;
	localparam int NMUTE_CYC = (NMUTE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
	localparam int TW_PULSES = 3;
	localparam int TMR_W = 24;
	localparam int IB1_MUTE_R = 1;
	localparam int IB1_MUTE_F = 2;
	localparam int IB1_GAIN_R = 3;
	localparam int IB1_GAIN_F = 4;
	localparam int IB1_OFS_EN = 5;
	localparam int IB1_DIAG_EN = 6;
	localparam int IB2_CUR_EN = 2;
	localparam int IB2_LINE = 3;
	localparam int IB2_RUN = 4;
	localparam int IB2_FMUTE = 5;
	localparam logic RST_ARM = 1'b1;
	typedef struct packed {logic gso; logic gsk; logic vs; logic sh; logic op;} sfd_cmp_t;
	typedef struct packed {logic gnd; logic vs; logic sh; logic op; logic perm;} sfd_res_t;
	typedef struct packed {
		logic [7:0] ib1;
		logic [7:0] ib2;
		logic rd_tgl;
		logic [2:0] twarn;
		logic biased;
		logic [3:0] scp;
		logic [3:0] cur;
		logic [3:0] ofs;
		sfd_cmp_t [3:0] cmp;
	} sfd_pin_t;
	typedef enum logic [1:0] {G_STBY = 2'b00, G_TON = 2'b01, G_RUN = 2'b10} sfd_gst_t;
	typedef enum logic [1:0] {C_ACT = 2'b00, C_CHK = 2'b01, C_DIAG = 2'b10, C_RST = 2'b11} sfd_cst_t;
endpackage

// ### sfd_seq.sv
// Four-channel load fault diagnostic sequencer: turn-on, permanent, offset and AC tests.
// Assumes bus logic presents the instruction bytes as levels and toggles rd_tgl per read.
// How it works
// [R1] Turn-on test pulse runs at standby exit when diagnostics are requested.
// [R2] Turn-on result held; next pulse allowed only after a read.
// [R3] Same-write standby exit and enable: pulse first, stage stays standby, outputs hi-Z.
// [R4] Permanent diagnostics once biased; turn-on result kept until a short appears.
// [R5] Output status latched at end of the 100 ms acquisition window.
// [R6] Load limits switch to line-driver set at 16 dB plus line-driver mode.
// [R7] Restart mode: faulted channel alone shuts down, rechecked every 1 ms.
// [R8] Diagnostic mode enabled by the host, starts on a protection trip.
// [R9] Recheck 1 ms after trip; no overload reactivates the channel.
// [R10] Persisting overload runs 100 ms cycle, stores result, enters restart.
// [R11] Next permanent cycle armed only by a host read.
// [R12] Host polls status periodically, preferably above half a second apart.
// [R13] Offset test from last read or enable; flag only if stable throughout.
// [R14] Protection trip during measurement suppresses offset and AC results.
// [R15] Fewer than three pulses above 500 mA reports open tweeter.
// [R16] Host plays at least three tone cycles before reading the AC result.
// [R17] Multiple faults reported one per read-and-removal round.
// [R18] Fault pairs resolve by fixed priority.
// [R19] Permanent diagnostics never report open load.
// [R20] Faults reported only if stable; a read re-arms and returns prior results.
// [R21] Fast-mute bit shortens mute below 1.5 ms; host clears it after.
// [R22] Three thermal warnings passed to the host.
// [R23] First instruction byte bit 6 enables diagnostics.
// [R24] Second instruction byte bit 3 selects line-driver thresholds.
// [R25] Second instruction byte bit 5 selects fast mute timing.
// [R26] Diagnostic byte bit 6 shows a terminated cycle.
// [R27] Each channel keeps its own state and result.
`timescale 1ns/1ps
`default_nettype none
module sfd_seq
	import sfd_pkg::*;
#(
	parameter int P_RECHECK = RECHECK_CYC,
	parameter int P_ACQ = ACQ_CYC,
	parameter int P_FMUTE = FMUTE_CYC,
	parameter int P_NMUTE = NMUTE_CYC
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// Pins from bus logic and comparators
	input wire sfd_pin_t pin_i,
	// Power stage control
	output logic standby_o,
	output logic out_hiz_o,
	output logic test_pulse_o,
	output logic [3:0] ch_en_o,
	output logic [3:0] thr_line_o,
	output logic mute_o,
	output logic fast_mute_o,
	// Diagnostic read data
	output sfd_res_t [3:0] res_o,
	output logic diag_done_o,
	output logic [3:0] offset_o,
	output logic [3:0] tw_open_o,
	output logic [2:0] twarn_o
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchroniser: three flops, a change counts when the last two agree

function automatic sfd_res_t resolve(input sfd_cmp_t c, input logic perm);
	sfd_res_t r;
	r.gnd = c.gso | (c.gsk & ~(c.op & ~perm));
	r.vs = c.vs;
	r.sh = c.sh & ~c.gso & ~c.gsk & ~c.vs;
	r.op = ~perm & c.op & ~c.gso & ~c.vs;
	r.perm = perm;
	return r;
endfunction

sfd_pin_t s1, s2, s3, st;
always_ff @(posedge clk_sys_i or negedge nrst_i) begin
	if (!nrst_i) begin
		s1 <= '0;
		s2 <= '0;
		s3 <= '0;
		st <= '0;
	end else begin
		s1 <= pin_i;
		s2 <= s1;
		s3 <= s2;
		st <= sfd_pin_t'((s2 & ~(s2 ^ s3)) | (st & (s2 ^ s3)));
	end
end

logic rd_q, ofs_q;
logic [3:0] cur_q;
always_ff @(posedge clk_sys_i or negedge nrst_i) begin
	if (!nrst_i) begin
		rd_q <= 1'b0;
		ofs_q <= 1'b0;
		cur_q <= '0;
	end else begin
		rd_q <= st.rd_tgl;
		ofs_q <= st.ib1[IB1_OFS_EN];
		cur_q <= st.cur;
	end
end
wire logic rd = st.rd_tgl ^ rd_q;
wire logic diag_en = st.ib1[IB1_DIAG_EN]; // [R23]
wire logic ofs_start = rd | (st.ib1[IB1_OFS_EN] & ~ofs_q);

////////////////////////////////////////////////////////////////////////////////
// Turn-on diagnostic

sfd_gst_t gst;
logic [TMR_W-1:0] gtmr;
logic ton_arm;
wire logic ton_end = gst == G_TON && gtmr == TMR_W'(P_ACQ - 1);
wire logic perm_on = gst == G_RUN && st.biased; // [R4]

always_ff @(posedge clk_sys_i or negedge nrst_i) begin
	if (!nrst_i) begin
		gst <= G_STBY;
		gtmr <= '0;
	end else begin
		gtmr <= (gst == G_TON) ? gtmr + 1'b1 : '0;
		unique case (gst)
			G_STBY: if (st.ib2[IB2_RUN]) gst <= (diag_en && ton_arm) ? G_TON : G_RUN; // [R1] [R3]
			G_TON: if (ton_end) gst <= G_RUN;
			G_RUN: if (!st.ib2[IB2_RUN]) gst <= G_STBY;
		endcase
	end
end

always_ff @(posedge clk_sys_i or negedge nrst_i) begin
	if (!nrst_i)
		ton_arm <= RST_ARM;
	else if (rd)
		ton_arm <= 1'b1;
	else if (ton_end)
		ton_arm <= 1'b0; // [R2]
end

////////////////////////////////////////////////////////////////////////////////
// Per-channel permanent diagnostics

sfd_cst_t cst [4];
logic [TMR_W-1:0] ctmr [4];
sfd_cmp_t acc [4];
logic [3:0] parm;
logic [3:0] cyc_end;

for (genvar i = 0; i < 4; i++) begin : g_ch
	wire logic tick = ctmr[i] == TMR_W'(P_RECHECK - 1);
	assign cyc_end[i] = cst[i] == C_DIAG && ctmr[i] == TMR_W'(P_ACQ - 1);
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cst[i] <= C_ACT;
			ctmr[i] <= '0;
		end else if (!perm_on) begin
			cst[i] <= C_ACT;
			ctmr[i] <= '0;
		end else begin
			ctmr[i] <= ctmr[i] + 1'b1;
			unique case (cst[i])
				C_ACT: begin
					ctmr[i] <= '0;
					if (st.scp[i]) cst[i] <= diag_en ? C_CHK : C_RST; // [R7] [R8]
				end
				C_CHK: if (tick) begin
					ctmr[i] <= '0;
					cst[i] <= !st.scp[i] ? C_ACT : (parm[i] ? C_DIAG : C_RST); // [R9] [R10]
				end
				C_DIAG: if (cyc_end[i]) begin
					ctmr[i] <= '0;
					cst[i] <= C_RST; // [R10]
				end
				C_RST: if (tick) begin
					ctmr[i] <= '0;
					if (!st.scp[i]) cst[i] <= C_ACT; // [R7]
				end
			endcase
		end
	end
	// Fault must hold on every sample of the window
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i)
			acc[i] <= '0;
		else if ((gst == G_STBY) || (cst[i] == C_CHK))
			acc[i] <= '1;
		else
			acc[i] <= acc[i] & st.cmp[i]; // [R20]
	end
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i)
			parm[i] <= RST_ARM;
		else if (rd)
			parm[i] <= 1'b1;
		else if (cyc_end[i])
			parm[i] <= 1'b0; // [R11]
	end
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i)
			res_o[i] <= '0;
		else if (ton_end)
			res_o[i] <= resolve(acc[i] & st.cmp[i], 1'b0); // [R5] [R17] [R18] [R27]
		else if (cyc_end[i] && |(acc[i] & st.cmp[i]))
			res_o[i] <= resolve(acc[i] & st.cmp[i], 1'b1); // [R4] [R19]
	end
end

////////////////////////////////////////////////////////////////////////////////
// Offset and AC current tests

sfd_cmp_t unused_cmp;
logic [3:0] ofs_acc, sup;
logic [1:0] pcnt [4];
for (genvar i = 0; i < 4; i++) begin : g_meas
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ofs_acc[i] <= 1'b0;
			sup[i] <= 1'b0;
			pcnt[i] <= '0;
		end else begin
			ofs_acc[i] <= ofs_start ? 1'b1 : ofs_acc[i] & st.ofs[i]; // [R13]
			sup[i] <= (rd || ofs_start) ? 1'b0 : sup[i] | st.scp[i]; // [R14]
			if (rd || !st.ib2[IB2_CUR_EN])
				pcnt[i] <= '0;
			else if (st.cur[i] && !cur_q[i] && pcnt[i] != 2'(TW_PULSES))
				pcnt[i] <= pcnt[i] + 1'b1; // [R15]
		end
	end
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			offset_o[i] <= 1'b0;
			tw_open_o[i] <= 1'b0;
		end else if (rd) begin
			offset_o[i] <= st.ib1[IB1_OFS_EN] & ofs_acc[i] & st.ofs[i] & ~sup[i]; // [R13] [R14]
			tw_open_o[i] <= st.ib2[IB2_CUR_EN] & (pcnt[i] != 2'(TW_PULSES)) & ~sup[i]; // [R15]
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Status and power stage outputs

always_ff @(posedge clk_sys_i or negedge nrst_i) begin
	if (!nrst_i)
		diag_done_o <= 1'b0;
	else if (ton_end || |cyc_end)
		diag_done_o <= 1'b1; // [R26]
	else if (rd)
		diag_done_o <= 1'b0;
end

logic [TMR_W-1:0] mtmr;
wire logic mute_req = !st.ib1[IB1_MUTE_F] && !st.ib1[IB1_MUTE_R];
wire logic [TMR_W-1:0] mlen = st.ib2[IB2_FMUTE] ? TMR_W'(P_FMUTE - 1) : TMR_W'(P_NMUTE - 1); // [R21] [R25]
always_ff @(posedge clk_sys_i or negedge nrst_i) begin
	if (!nrst_i) begin
		mtmr <= '0;
		mute_o <= 1'b1;
	end else if (!mute_req) begin
		mtmr <= '0;
		mute_o <= 1'b0;
	end else if (!mute_o) begin
		mtmr <= mtmr + 1'b1;
		if (mtmr >= mlen) mute_o <= 1'b1; // [R21]
	end
end

always_ff @(posedge clk_sys_i or negedge nrst_i) begin
	if (!nrst_i) begin
		standby_o <= 1'b1;
		out_hiz_o <= 1'b1;
		test_pulse_o <= 1'b0;
		ch_en_o <= '0;
		thr_line_o <= '0;
		fast_mute_o <= 1'b0;
		twarn_o <= '0;
	end else begin
		standby_o <= gst != G_RUN; // [R3]
		out_hiz_o <= gst != G_RUN;
		test_pulse_o <= gst == G_TON; // [R1]
		for (int i = 0; i < 4; i++)
			ch_en_o[i] <= gst == G_RUN && cst[i] == C_ACT; // [R7]
		thr_line_o <= {4{st.ib2[IB2_LINE]}} & {st.ib1[IB1_GAIN_R], st.ib1[IB1_GAIN_F],
			st.ib1[IB1_GAIN_R], st.ib1[IB1_GAIN_F]}; // [R6] [R24]
		fast_mute_o <= st.ib2[IB2_FMUTE]; // [R25]
		twarn_o <= st.twarn; // [R22]
	end
end

////////////////////////////////////////////////////////////////////////////////
// Checks

default clocking cb @(posedge clk_sys_i); endclocking
default disable iff (!nrst_i);

chk_ton_start: assert property (gst == G_STBY && st.ib2[IB2_RUN] && diag_en && ton_arm |=> gst == G_TON) // [R1]
	else $error("turn-on pulse not started");
chk_ton_arm: assert property (!ton_arm && !rd |=> !ton_arm) // [R2]
	else $error("turn-on re-armed without read");
chk_ton_hiz: assert property (gst == G_TON |-> ##1 (standby_o && out_hiz_o && test_pulse_o)) // [R3]
	else $error("stage left standby during pulse");
chk_restart_iso: assert property (perm_on && cst[3] == C_ACT && st.scp[3] && !diag_en ##1 perm_on
	|-> cst[3] == C_RST ##1 !ch_en_o[3]) // [R7]
	else $error("restart shutdown missing");
chk_diag_trip: assert property (perm_on && cst[2] == C_ACT && st.scp[2] && diag_en ##1 perm_on
	|-> cst[2] == C_CHK) // [R8]
	else $error("diag check not entered");
chk_recheck_ok: assert property (perm_on && cst[3] == C_CHK && !st.scp[3] && ctmr[3] == TMR_W'(P_RECHECK - 1)
	##1 perm_on |-> cst[3] == C_ACT) // [R9]
	else $error("channel not reactivated");
chk_cycle_len: assert property ($rose(cst[2] == C_DIAG) |-> (cst[2] == C_DIAG || !perm_on)[*8]) // [R10]
	else $error("diag cycle cut short");
chk_perm_arm: assert property (!parm[2] && !rd |=> !parm[2]) // [R11]
	else $error("permanent cycle re-armed without read");
chk_no_open: assert property (res_o[2].perm |-> !res_o[2].op) // [R19]
	else $error("open load from permanent diag");
chk_done_set: assert property (ton_end |=> diag_done_o) // [R26]
	else $error("done flag not set");
chk_tw_count: assert property (rd && st.ib2[IB2_CUR_EN] && !sup[0] && pcnt[0] == 2'(TW_PULSES) |=> !tw_open_o[0]) // [R15]
	else $error("tweeter wrongly open");

cov_ton: cover property (ton_end ##1 gst == G_RUN);
cov_perm: cover property (cyc_end[0] ##1 cst[0] == C_RST);
cov_read: cover property (rd && diag_done_o);

endmodule
`default_nettype wire

// ### sfd_host.sv
// Host model: writes the two instruction bytes and performs reads.
// Assumes the bench calls its tasks; outputs change on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module sfd_host (
	// Clock
	input wire logic clk_sys_i,
	// Bus-decoded levels
	output logic [7:0] ib1_o,
	output logic [7:0] ib2_o,
	output logic rd_tgl_o
);
	initial begin
		ib1_o = 8'h00;
		ib2_o = 8'h00;
		rd_tgl_o = 1'b0;
	end
	// Also used to drop the fast-mute bit after the transition
	task wr(input logic [7:0] a, input logic [7:0] b);
		@(negedge clk_sys_i);
		ib1_o = a;
		ib2_o = b;
		repeat (6) @(negedge clk_sys_i);
	endtask
	// Each read toggles rd_tgl, then waits eight cycles before returning
	task rd();
		@(negedge clk_sys_i);
		rd_tgl_o = ~rd_tgl_o;
		repeat (8) @(negedge clk_sys_i);
	endtask
endmodule
`default_nettype wire

// ### speaker_fault_diag_sequencer_tb.sv
// Self-checking bench for the diagnostic sequencer with shortened counts.
// Assumes sfd_pkg and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module speaker_fault_diag_sequencer_tb;
	import sfd_pkg::*;
	localparam int RC = 20;
	localparam int AQ = 40;
	logic clk_sys_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [7:0] ib1, ib2;
	logic rd_tgl = 1'b0;
	logic [2:0] twarn = 3'b000;
	logic biased = 1'b0;
	logic [3:0] scp = 4'h0, cur = 4'h0, ofs = 4'h0;
	sfd_cmp_t [3:0] cmp = '0;
	sfd_pin_t pins;
	logic standby, hiz, tp, mute, fmute, dd;
	logic [3:0] ch_en, thr, offs, tw;
	logic [2:0] tw_o;
	sfd_res_t [3:0] res;
	int n_fail = 0;
	int checked = 0;
	assign pins = {ib1, ib2, rd_tgl, twarn, biased, scp, cur, ofs, cmp};
	initial begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	sfd_host host (.clk_sys_i(clk_sys_i), .ib1_o(ib1), .ib2_o(ib2), .rd_tgl_o(rd_tgl));
	sfd_seq #(.P_RECHECK(RC), .P_ACQ(AQ), .P_FMUTE(10), .P_NMUTE(30)) dut (.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i), .pin_i(pins), .standby_o(standby), .out_hiz_o(hiz), .test_pulse_o(tp),
		.ch_en_o(ch_en), .thr_line_o(thr), .mute_o(mute), .fast_mute_o(fmute), .res_o(res),
		.diag_done_o(dd), .offset_o(offs), .tw_open_o(tw), .twarn_o(tw_o));
	////////////////////////////////////////////////////////////////////////////////
	task end_sim();
		if (n_fail == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
			n_fail++;
		end
	endtask
	function automatic logic sig(input int s);
		case (s)
			0: sig = tp;
			1: sig = dd;
			2: sig = mute;
			3: sig = ch_en[2];
			default: sig = ch_en[3];
		endcase
	endfunction
	// Bounded wait until the selected output equals v
	task wt(input int s, input logic v, input int lim);
		int k;
		k = 0;
		while (sig(s) !== v) begin
			@(negedge clk_sys_i);
			k++;
			if (k > lim) begin
				$display("[ERR] wait %0d expected %b seen timeout", s, v);
				n_fail++;
				end_sim();
			end
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task s_turnon();
		chk("standby", 1, standby);
		chk("mute", 1, mute);
		cmp[0] = 5'b10000;
		cmp[1] = 5'b00001;
		host.wr(8'h40, 8'h10);
		wt(0, 1'b1, 20);
		chk("stby_pulse", 2'b11, {standby, hiz});
		wt(1, 1'b1, AQ + 20);
		chk("res0", 5'b10000, res[0]);
		chk("res1", 5'b00010, res[1]);
		repeat (3) @(negedge clk_sys_i);
		chk("ch_en", 4'hf, ch_en);
		chk("run_stage", 3'b000, {standby, hiz, tp});
		cmp[0] = 5'b00000;
		host.rd();
		chk("done_clr", 0, dd);
		chk("res0_held", 5'b10000, res[0]);
	endtask
	task s_perm();
		biased = 1'b1;
		cmp[2] = 5'b00011;
		scp[2] = 1'b1;
		wt(3, 1'b0, 10);
		chk("ch0_on", 1, ch_en[0]);
		wt(1, 1'b1, RC + AQ + 20);
		chk("res2", 5'b00101, res[2]);
		chk("res0_kept", 5'b10000, res[0]);
		scp[2] = 1'b0;
		cmp[2] = 5'b00000;
		wt(3, 1'b1, RC + 15);
		host.rd();
		scp[3] = 1'b1;
		repeat (6) @(negedge clk_sys_i);
		scp[3] = 1'b0;
		wt(4, 1'b0, 10);
		wt(4, 1'b1, RC + 15);
		chk("no_diag", 1'b0, dd);
		chk("res3", 5'b00000, res[3]);
		host.wr(8'h00, 8'h10);
		scp[3] = 1'b1;
		wt(4, 1'b0, 10);
		chk("ch2_on_rst", 1, ch_en[2]);
		scp[3] = 1'b0;
		wt(4, 1'b1, RC + 15);
		chk("no_diag_rst", 0, dd);
	endtask
	task s_mute();
		host.wr(8'h44, 8'h30);
		chk("unmuted", 0, mute);
		chk("fmute", 1, fmute);
		host.wr(8'h40, 8'h30);
		chk("mute_early", 0, mute);
		wt(2, 1'b1, 20);
		host.wr(8'h44, 8'h10);
		chk("unmuted_n", 0, mute);
		chk("fmute_off", 0, fmute);
		host.wr(8'h40, 8'h10);
		repeat (12) @(negedge clk_sys_i);
		chk("mute_norm_early", 0, mute);
		wt(2, 1'b1, 40);
		host.wr(8'h50, 8'h18);
		chk("thr_line", 4'b0101, thr);
		twarn = 3'b101;
		repeat (8) @(negedge clk_sys_i);
		chk("twarn", 3'b101, tw_o);
	endtask
	task s_ofs();
		ofs[1] = 1'b1;
		host.wr(8'h60, 8'h14);
		host.rd();
		// Tone stands in for three sine cycles before the result read
		repeat (3) begin
			cur[0] = 1'b1;
			repeat (4) @(negedge clk_sys_i);
			cur[0] = 1'b0;
			repeat (4) @(negedge clk_sys_i);
		end
		host.rd();
		chk("offset", 4'b0010, offs);
		chk("tw_open", 4'b1110, tw);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(negedge clk_sys_i);
		nrst_i = 1'b1;
		s_turnon();
		s_perm();
		s_mute();
		s_ofs();
		end_sim();
	end
endmodule
`default_nettype wire
